// [inc/sfcfe_consts.svh]
`ifndef SFCFE_CONSTS_SVH
`define SFCFE_CONSTS_SVH
`define SFCFE_OP_LATCH_SET 8'h06
`define SFCFE_OP_LATCH_CLR 8'h04
`define SFCFE_OP_ID_READ 8'h9F
`define SFCFE_OP_STAT_READ 8'h05
`define SFCFE_OP_STAT_WRITE 8'h01
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST_READ 8'h0B
`define SFCFE_OP_SMALL_WIPE 8'h20
`define SFCFE_OP_LARGE_WIPE_A 8'h52
`define SFCFE_OP_LARGE_WIPE_B 8'hD8
`define SFCFE_OP_FULL_WIPE_A 8'h60
`define SFCFE_OP_FULL_WIPE_B 8'hC7
`define SFCFE_OP_PAGE_WRITE 8'h02
`define SFCFE_OP_LP_ENTRY 8'hB9
`define SFCFE_OP_LP_EXIT 8'hAB
`define SFCFE_OP_MAKER_PART 8'h90
`define SFCFE_ST_BUSY_BIT 0
`define SFCFE_ST_LATCH_BIT 1
`define SFCFE_ST_WR_MASK 8'h9C
`define SFCFE_ADDR_MASK 24'h0FFFFF
`define SFCFE_SECTOR_MASK 24'h0FF000
`define SFCFE_BLOCK_MASK 24'h0F0000
`define SFCFE_ADDR_BYTES 3'h3
`define SFCFE_CNT_W 16
`endif

// [inc/sfcfe_pkg.sv]
package sfcfe_pkg;
	// Link-side command progress
	typedef enum logic [2:0] {
		ST_OPC = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_OUT = 3'b011,
		ST_SINK = 3'b100,
		ST_IGNORE = 3'b101
	} sfcfe_state_e;
	// Internal operation kinds
	typedef enum logic [2:0] {
		OP_STATUS = 3'b000,
		OP_PAGE = 3'b001,
		OP_SMALL = 3'b010,
		OP_LARGE = 3'b011,
		OP_FULL = 3'b100
	} sfcfe_op_e;
endpackage

// [rtl/sfcfe_sync3.sv]
`timescale 1ns/10ps
module sfcfe_sync3 #(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [W-1:0] rst_val, // Level held in reset
	input wire logic [W-1:0] d, // Foreign-domain level
	output logic [W-1:0] q // Agreed level
);
	logic [W-1:0] q1_reg;
	logic [W-1:0] q2_reg;
	logic [W-1:0] q3_reg;

	// Three stages; the first feeds only the second
	always_ff @(posedge clk) begin
		q1_reg <= d;
		q2_reg <= q1_reg;
		q3_reg <= q2_reg;
	end

	// Adopt a change only when late stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= rst_val;
		end else if (q2_reg == q3_reg) begin
			q <= q3_reg;
		end
	end
endmodule

// [rtl/sfcfe_op_timer.sv]
`timescale 1ns/10ps
`include "sfcfe_consts.svh"
module sfcfe_op_timer (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic start, // Begin an operation
	input wire logic [`SFCFE_CNT_W-1:0] load_cnt, // Cycles it lasts
	output logic busy, // Operation running
	output logic done // Pulse at completion
);
	logic [`SFCFE_CNT_W-1:0] cnt_reg;

	// Down-counter; start is ignored while running
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				cnt_reg <= load_cnt;
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt_reg <= `SFCFE_CNT_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - `SFCFE_CNT_W'(1);
				end
			end
		end
	end
endmodule

// [rtl/sfcfe_front_end.sv]
`timescale 1ns/10ps
`include "sfcfe_consts.svh"
module sfcfe_front_end
	import sfcfe_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] MEM_TYPE_ID = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h11, // Arbitrary value
	parameter int unsigned STATUS_CYC = 200, // Status write length
	parameter int unsigned PAGE_CYC = 400, // Page write length
	parameter int unsigned SMALL_CYC = 800, // Small wipe length
	parameter int unsigned LARGE_CYC = 1600, // Large wipe length
	parameter int unsigned FULL_CYC = 3200 // Full wipe length
) (
	input wire logic clock, // System clock, 20 MHz
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic sclk, // Link clock from master
	input wire logic select_n, // Chip select, low active
	input wire logic si, // Serial data in
	input wire logic pause_n, // Pause request, low active
	output logic so_out, // Serial data out
	output logic so_oe_n, // SO drive enable, low active
	output logic [23:0] rd_addr, // Array read address (link)
	input wire logic [7:0] rd_data, // Array byte at rd_addr
	output logic op_start, // Internal operation start pulse
	output sfcfe_op_e op_kind, // Kind of operation
	output logic [23:0] op_addr, // Region of operation
	output logic [7:0] status_byte, // Status as read by master
	output logic low_power // Low-power mode level
);
	////////////////////////////////////////////////////////////
	// Link side: frame and pause tracking
	logic fresh_reg;
	logic held_reg;
	logic pause_active;
	logic frame_tog_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] byte_cnt_reg;
	logic [6:0] sh_reg;
	logic [7:0] cmd_reg;
	logic [7:0] wdata_reg;
	logic [23:0] addr_reg;
	logic [1:0] out_idx_reg;
	logic order_reg;
	logic so_reg;
	logic so_oe_n_reg;
	sfcfe_state_e state_reg;
	sfcfe_state_e state_next;
	logic [2:0] eff_bit;
	sfcfe_state_e eff_state;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] out_byte;
	logic [8:0] link_view;
	logic link_busy;
	logic link_lp;
	logic [7:0] link_status;

	// Status and mode seen from the link clock
	sfcfe_sync3 #(.W(9)) u_link_sync (
		.clk(sclk),
		.rst(1'b0),
		.rst_val(9'h000),
		.d({low_power, status_byte}),
		.q(link_view)
	);
	assign link_lp = link_view[8];
	assign link_status = link_view[7:0];
	assign link_busy = link_view[`SFCFE_ST_BUSY_BIT];

	// Frame marker, forced while deselected
	always_ff @(posedge sclk or posedge select_n) begin
		if (select_n) begin
			fresh_reg <= 1'b1;
		end else if (pause_n) begin // A paused rise does not open the frame
			fresh_reg <= 1'b0;
		end
	end

	// Pause level captured as SCLK rises; it stands for the whole high phase
	always_ff @(posedge sclk or posedge select_n) begin
		if (select_n) begin
			held_reg <= 1'b0;
		end else begin
			held_reg <= ~pause_n;
		end
	end

	// Pause follows the pin only while SCLK is low
	assign pause_active = ~select_n & (sclk ? held_reg : ~pause_n);

	// First rising edge of a frame restarts all counts
	assign eff_bit = fresh_reg ? 3'h0 : bit_cnt_reg;
	assign eff_state = fresh_reg ? ST_OPC : state_reg;
	assign byte_done = (eff_bit == 3'h7);
	assign rx_byte = {sh_reg, si};

	// Opcode decode; unknown codes fall into ignore
	function automatic sfcfe_state_e opc_decode(input logic [7:0] code, input logic lp, input logic busy);
		sfcfe_state_e st;
		st = ST_IGNORE;
		if (lp) begin
			if (code == `SFCFE_OP_LP_EXIT) begin
				st = ST_ADDR;
			end
		end else begin
			case (code)
				`SFCFE_OP_LATCH_SET, `SFCFE_OP_LATCH_CLR, `SFCFE_OP_LP_ENTRY,
				`SFCFE_OP_FULL_WIPE_A, `SFCFE_OP_FULL_WIPE_B, `SFCFE_OP_STAT_WRITE: begin
					st = ST_SINK;
				end
				`SFCFE_OP_STAT_READ: begin
					st = ST_OUT;
				end
				`SFCFE_OP_ID_READ: begin
					st = busy ? ST_IGNORE : ST_OUT;
				end
				`SFCFE_OP_READ, `SFCFE_OP_FAST_READ: begin
					st = busy ? ST_IGNORE : ST_ADDR;
				end
				`SFCFE_OP_SMALL_WIPE, `SFCFE_OP_LARGE_WIPE_A, `SFCFE_OP_LARGE_WIPE_B,
				`SFCFE_OP_PAGE_WRITE, `SFCFE_OP_MAKER_PART, `SFCFE_OP_LP_EXIT: begin
					st = ST_ADDR;
				end
				default: begin
					st = ST_IGNORE;
				end
			endcase
		end
		return st;
	endfunction

	// Progress through opcode, address, dummy and payload
	always_comb begin
		state_next = eff_state;
		if (byte_done) begin
			unique case (eff_state)
				ST_OPC: begin
					state_next = opc_decode(rx_byte, link_lp, link_busy);
				end
				ST_ADDR: begin
					if (byte_cnt_reg == `SFCFE_ADDR_BYTES) begin
						unique case (cmd_reg)
							`SFCFE_OP_READ, `SFCFE_OP_MAKER_PART, `SFCFE_OP_LP_EXIT: begin
								state_next = ST_OUT;
							end
							`SFCFE_OP_FAST_READ: begin
								state_next = ST_DUMMY;
							end
							default: begin
								state_next = ST_SINK;
							end
						endcase
					end
				end
				ST_DUMMY: begin
					state_next = ST_OUT;
				end
				ST_OUT, ST_SINK, ST_IGNORE: begin
					state_next = eff_state;
				end
				default: begin
					state_next = ST_IGNORE;
				end
			endcase
		end
	end

	// Bit and byte counters, frozen during a pause; the pin level at a rise
	// is the pause state of the low phase just ended
	always_ff @(posedge sclk) begin
		if (pause_n) begin
			bit_cnt_reg <= eff_bit + 3'h1;
			sh_reg <= {sh_reg[5:0], si};
			if (fresh_reg) begin
				byte_cnt_reg <= 3'h0;
			end else if (byte_done && byte_cnt_reg != 3'h7) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
	end

	// Frame toggle tells the system side a frame had clocks; system reset
	// clears it while SCLK is parked, and deselected edges never count
	always_ff @(posedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_tog_reg <= 1'b0;
		end else if (fresh_reg && !select_n && pause_n) begin
			frame_tog_reg <= ~frame_tog_reg;
		end
	end

	// Command state and opcode capture
	always_ff @(posedge sclk) begin
		if (pause_n) begin
			state_reg <= state_next;
			if (byte_done && eff_state == ST_OPC) begin
				cmd_reg <= rx_byte;
			end
		end
	end

	// Address, order and status payload capture
	always_ff @(posedge sclk) begin
		if (pause_n && byte_done) begin
			if (eff_state == ST_ADDR) begin
				addr_reg <= {addr_reg[15:0], rx_byte};
				order_reg <= rx_byte[0];
			end else if (eff_state == ST_OUT &&
				(cmd_reg == `SFCFE_OP_READ || cmd_reg == `SFCFE_OP_FAST_READ)) begin
				addr_reg <= (addr_reg + 24'h000001) & `SFCFE_ADDR_MASK;
			end
			if (eff_state == ST_SINK && cmd_reg == `SFCFE_OP_STAT_WRITE && byte_cnt_reg == 3'h1) begin
				wdata_reg <= rx_byte;
			end
		end
	end

	// Output byte index, restarted per frame
	always_ff @(posedge sclk) begin
		if (fresh_reg || eff_state != ST_OUT) begin
			out_idx_reg <= 2'h0;
		end else if (pause_n && byte_done) begin
			out_idx_reg <= (out_idx_reg == 2'h2) ? 2'h0 : out_idx_reg + 2'h1;
		end
	end
	assign rd_addr = addr_reg;

	// Byte presented on SO for the current command
	always_comb begin
		out_byte = 8'h00;
		unique case (cmd_reg)
			`SFCFE_OP_STAT_READ: begin
				out_byte = link_status;
			end
			`SFCFE_OP_READ, `SFCFE_OP_FAST_READ: begin
				out_byte = rd_data;
			end
			`SFCFE_OP_ID_READ: begin
				if (out_idx_reg == 2'h0) begin
					out_byte = MAKER_ID;
				end else if (out_idx_reg == 2'h1) begin
					out_byte = MEM_TYPE_ID;
				end else begin
					out_byte = DEVICE_ID;
				end
			end
			`SFCFE_OP_MAKER_PART: begin
				out_byte = (out_idx_reg[0] ^ order_reg) ? DEVICE_ID : MAKER_ID;
			end
			`SFCFE_OP_LP_EXIT: begin
				out_byte = DEVICE_ID;
			end
			default: begin
				out_byte = 8'h00;
			end
		endcase
	end

	// SO shifts on the falling edge, MSB first
	always_ff @(negedge sclk or posedge select_n) begin
		if (select_n) begin
			so_reg <= 1'b0;
			so_oe_n_reg <= 1'b1;
		end else if (fresh_reg) begin
			so_oe_n_reg <= 1'b1;
		end else if (pause_n) begin
			so_oe_n_reg <= (state_reg != ST_OUT);
			so_reg <= out_byte[3'h7 - bit_cnt_reg];
		end
	end

	// Pause floats SO at once while SCLK is low, without waiting for an edge
	assign so_out = so_reg;
	assign so_oe_n = so_oe_n_reg | pause_active | select_n;

	////////////////////////////////////////////////////////////
	// System side: frame-end evaluation
	logic sel_lvl;
	logic sel_lvl_d_reg;
	logic frame_end;
	logic seen_tog_reg;
	logic latch_reg;
	logic lp_reg;
	logic [7:0] sr_bits_reg;
	logic op_busy;
	logic op_done;
	logic start_reg;
	sfcfe_op_e kind_reg;
	logic [23:0] oaddr_reg;
	logic [`SFCFE_CNT_W-1:0] load_cnt;
	logic boundary_ok;
	logic write_ok;
	logic [7:0] end_cmd;

	sfcfe_sync3 #(.W(1)) u_sel_sync (
		.clk(clock),
		.rst(sys_rst),
		.rst_val(1'b1),
		.d(select_n),
		.q(sel_lvl)
	);

	// Rising select_n ends the frame; link logic is idle then
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sel_lvl_d_reg <= 1'b1;
		end else begin
			sel_lvl_d_reg <= sel_lvl;
		end
	end
	assign frame_end = sel_lvl & ~sel_lvl_d_reg;

	// Link registers are stable while SCLK is parked after deselect
	assign end_cmd = cmd_reg;
	assign boundary_ok = (bit_cnt_reg == 3'h0) && (byte_cnt_reg != 3'h0) &&
		(state_reg != ST_IGNORE) && (frame_tog_reg != seen_tog_reg);
	assign write_ok = latch_reg && !op_busy && !op_done && !lp_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			seen_tog_reg <= 1'b0;
		end else if (frame_end) begin
			seen_tog_reg <= frame_tog_reg;
		end
	end

	// Operation launch on a valid write-type frame
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			start_reg <= 1'b0;
			kind_reg <= OP_STATUS;
			oaddr_reg <= 24'h000000;
		end else begin
			start_reg <= 1'b0;
			if (frame_end && boundary_ok && write_ok) begin
				oaddr_reg <= addr_reg & `SFCFE_ADDR_MASK;
				unique case (end_cmd)
					`SFCFE_OP_STAT_WRITE: begin
						if (byte_cnt_reg == 3'h2) begin
							start_reg <= 1'b1;
							kind_reg <= OP_STATUS;
						end
					end
					`SFCFE_OP_PAGE_WRITE: begin
						if (byte_cnt_reg > 3'h4) begin
							start_reg <= 1'b1;
							kind_reg <= OP_PAGE;
						end
					end
					`SFCFE_OP_SMALL_WIPE: begin
						if (byte_cnt_reg == 3'h4) begin
							start_reg <= 1'b1;
							kind_reg <= OP_SMALL;
							oaddr_reg <= addr_reg & `SFCFE_SECTOR_MASK;
						end
					end
					`SFCFE_OP_LARGE_WIPE_A, `SFCFE_OP_LARGE_WIPE_B: begin
						if (byte_cnt_reg == 3'h4) begin
							start_reg <= 1'b1;
							kind_reg <= OP_LARGE;
							oaddr_reg <= addr_reg & `SFCFE_BLOCK_MASK;
						end
					end
					`SFCFE_OP_FULL_WIPE_A, `SFCFE_OP_FULL_WIPE_B: begin
						if (byte_cnt_reg == 3'h1) begin
							start_reg <= 1'b1;
							kind_reg <= OP_FULL;
						end
					end
					default: begin
						start_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Length of the launched operation
	always_comb begin
		unique case (kind_reg)
			OP_STATUS: load_cnt = `SFCFE_CNT_W'(STATUS_CYC);
			OP_PAGE: load_cnt = `SFCFE_CNT_W'(PAGE_CYC);
			OP_SMALL: load_cnt = `SFCFE_CNT_W'(SMALL_CYC);
			OP_LARGE: load_cnt = `SFCFE_CNT_W'(LARGE_CYC);
			OP_FULL: load_cnt = `SFCFE_CNT_W'(FULL_CYC);
			default: load_cnt = `SFCFE_CNT_W'(STATUS_CYC);
		endcase
	end

	// Runs on regardless of the link, pause included
	sfcfe_op_timer u_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(start_reg),
		.load_cnt(load_cnt),
		.busy(op_busy),
		.done(op_done)
	);

	// Write latch: set wins over a same-cycle clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			latch_reg <= 1'b0;
		end else if (frame_end && boundary_ok && end_cmd == `SFCFE_OP_LATCH_SET &&
			byte_cnt_reg == 3'h1 && !lp_reg) begin
			latch_reg <= 1'b1;
		end else if (op_done) begin
			latch_reg <= 1'b0;
		end else if (frame_end && boundary_ok && end_cmd == `SFCFE_OP_LATCH_CLR &&
			byte_cnt_reg == 3'h1 && !lp_reg) begin
			latch_reg <= 1'b0;
		end
	end

	// Stored status bits; busy and latch bits are not writable
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sr_bits_reg <= 8'h00;
		end else if (start_reg && kind_reg == OP_STATUS) begin
			sr_bits_reg <= wdata_reg & `SFCFE_ST_WR_MASK;
		end
	end

	// Low-power entry and exit, only on whole bytes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lp_reg <= 1'b0;
		end else if (frame_end && boundary_ok) begin
			if (end_cmd == `SFCFE_OP_LP_ENTRY && byte_cnt_reg == 3'h1 && !op_busy) begin
				lp_reg <= 1'b1;
			end else if (end_cmd == `SFCFE_OP_LP_EXIT) begin
				lp_reg <= 1'b0;
			end
		end
	end

	// Status byte assembled for the master
	always_comb begin
		status_byte = sr_bits_reg;
		status_byte[`SFCFE_ST_BUSY_BIT] = op_busy | op_done; // Busy and latch fall together
		status_byte[`SFCFE_ST_LATCH_BIT] = latch_reg;
	end

	assign op_start = start_reg;
	assign op_kind = kind_reg;
	assign op_addr = oaddr_reg;
	assign low_power = lp_reg;
endmodule

// [test/sfcfe_monitor.sv]
`timescale 1ns/10ps
module sfcfe_monitor
	import sfcfe_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic sys_rst, // Reset, high
	input wire logic sclk, // Link clock
	input wire logic select_n, // Chip select, low
	input wire logic pause_n, // Pause, low
	input wire logic so_oe_n, // SO enable, low
	input wire logic op_start, // Operation launch
	input wire sfcfe_op_e op_kind, // Operation kind
	input wire logic [23:0] op_addr, // Operation region
	input wire logic [7:0] status_byte, // Status view
	input wire logic low_power // Low-power level
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// Link pin behaviour, sampled in the system domain
	deselect_float_a: assert property (select_n |-> so_oe_n)
		else $error("SO driven while deselected");
	pause_float_a: assert property (!pause_n && !sclk |-> so_oe_n)
		else $error("SO driven while paused");
	////////////////////////////////////////////////////////////////
	// Launch only after a whole frame, latched and idle
	start_deselected_a: assert property (op_start |-> select_n && $past(select_n, 3))
		else $error("Operation launched inside a frame");
	start_gated_a: assert property (op_start |-> status_byte[1] && !status_byte[0])
		else $error("Operation launched without latch or while busy");
	busy_follows_a: assert property (op_start |=> status_byte[0] && !op_start)
		else $error("Busy flag missing after launch");
	addr_map_a: assert property (op_start |-> op_addr[23:20] == 4'h0)
		else $error("Operation address outside map");
	sector_align_a: assert property (op_start && op_kind == OP_SMALL |-> op_addr[11:0] == 12'h000)
		else $error("Small wipe not sector aligned");
	block_align_a: assert property (op_start && op_kind == OP_LARGE |-> op_addr[15:0] == 16'h0000)
		else $error("Large wipe not block aligned");
	// Completion clears the latch within a cycle
	latch_clear_a: assert property ($fell(status_byte[0]) |-> ##[0:1] !status_byte[1])
		else $error("Latch kept after completion");
	reset_state_a: assert property ($fell(sys_rst) |-> status_byte == 8'h00 && !low_power && !op_start)
		else $error("State not cleared by reset");
endmodule
////////////////////////////////////////////////////////////////
bind sfcfe_front_end sfcfe_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
	.select_n(select_n), .pause_n(pause_n), .so_oe_n(so_oe_n), .op_start(op_start),
	.op_kind(op_kind), .op_addr(op_addr), .status_byte(status_byte), .low_power(low_power));

// [test/sfcfe_spi_master.sv]
`timescale 1ns/10ps
module sfcfe_spi_master (
	output logic sclk, // Link clock, idle low
	output logic select_n, // Chip select, low
	output logic si, // Data to device
	output logic pause_n, // Pause, low
	input wire logic so_out, // Device data
	input wire logic so_oe_n // Device enable, low
);
	logic so_last;
	logic so_line;
	logic drove;
	initial begin
		sclk = 1'b0;
		select_n = 1'b1;
		si = 1'b0;
		pause_n = 1'b1;
		so_last = 1'b0;
		drove = 1'b0;
	end
	// Released SO shows the inverse level, so a stale bit never passes
	always @(so_out or so_oe_n) begin
		if (!so_oe_n) so_last = so_out;
	end
	assign so_line = so_oe_n ? ~so_last : so_out;
	always @(negedge so_oe_n) begin
		drove = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// Frame control; clock stands still outside frames
	task automatic sel();
		drove = 1'b0;
		select_n = 1'b0;
		#20;
	endtask
	// Long gap so the system domain sees the frame end
	task automatic desel();
		#20;
		select_n = 1'b1;
		#300;
	endtask
	// Mode 0 byte, MSB first, device bit read at the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si = tx[i];
			#16;
			rx[i] = so_line;
			sclk = 1'b1;
			#16;
			sclk = 1'b0;
		end
	endtask
	// Mode 3 byte: clock parked high, falls first, rises to sample
	task automatic xfer3(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			si = tx[i];
			#16;
			rx[i] = so_line;
			sclk = 1'b1;
			#16;
		end
	endtask
	// Idle level of the clock between frames
	task automatic park(input logic v);
		sclk = v;
		#20;
	endtask
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++) begin
			si = ~si;
			#16;
			sclk = 1'b1;
			#16;
			sclk = 1'b0;
		end
	endtask
	// Pause edges only while the clock is low
	task automatic hold(input logic v);
		#8;
		pause_n = v;
		#8;
	endtask
endmodule

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
	import sfcfe_pkg::*;
	localparam logic [7:0] MK = 8'h5A; // Arbitrary value
	localparam logic [7:0] MT = 8'h3C; // Arbitrary value
	localparam logic [7:0] DV = 8'h11; // Arbitrary value
	logic clock, sys_rst, sclk, select_n, si, pause_n, so_out, so_oe_n, op_start, low_power;
	logic [23:0] rd_addr, op_addr, last_addr;
	logic [7:0] rd_data, status_byte, b, st;
	logic [63:0] rx;
	sfcfe_op_e op_kind, last_kind;
	int n_errors = 0;
	int n_compared = 0;
	int n_starts = 0;
	// Array model: each byte tied to its address
	assign rd_data = rd_addr[7:0] ^ 8'hA5;
	// Default identities and operation lengths; MK, MT and DV mirror them
	sfcfe_front_end dut (.clock(clock), .sys_rst(sys_rst), .sclk(sclk),
		.select_n(select_n), .si(si), .pause_n(pause_n), .so_out(so_out), .so_oe_n(so_oe_n), .rd_addr(rd_addr),
		.rd_data(rd_data), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
		.status_byte(status_byte), .low_power(low_power));
	sfcfe_spi_master master (.sclk(sclk), .select_n(select_n), .si(si), .pause_n(pause_n),
		.so_out(so_out), .so_oe_n(so_oe_n));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Launch capture mid-cycle, clear of the edge
	always @(negedge clock) begin
		if (op_start === 1'b1) begin
			n_starts++;
			last_kind = op_kind;
			last_addr = op_addr;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Whole frame, bytes taken from the top of tx
	task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] r);
		logic [7:0] x;
		r = 64'h0;
		master.sel();
		for (int i = 0; i < n; i++) begin
			master.xfer(tx[63-8*i -: 8], x);
			r = {r[55:0], x};
		end
		master.desel();
	endtask
	task automatic status_read_cmd(output logic [7:0] s);
		logic [63:0] r;
		frame(2, {8'h05, 56'h0}, r);
		s = r[7:0];
	endtask
	// Bounded busy poll; a hang ends the run
	task automatic wait_idle();
		logic [7:0] s;
		logic seen;
		seen = 1'b0;
		// Longest operation is 3200 cycles, one poll about 17
		for (int i = 0; i < 300; i++) begin
			status_read_cmd(s);
			if (s[0] === 1'b0) break;
			seen = 1'b1;
		end
		if (s[0] !== 1'b0) begin
			n_errors++;
			finish_test();
		end
		chk(seen, 1'b1);
		chk(s[1], 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_ident();
		frame(5, {8'h9F, 56'h0}, rx);
		chk(rx[31:0], {MK, MT, DV, MK});
		for (int o = 0; o < 2; o++) begin
			frame(7, {8'h90, 23'h0, o[0], 32'h0}, rx);
			chk(rx[23:0], o ? {DV, MK, DV} : {MK, DV, MK});
		end
		frame(7, {8'h03, 24'h0FFFFE, 32'h0}, rx);
		chk(rx[23:0], {8'hFE ^ 8'hA5, 8'hFF ^ 8'hA5, 8'h00 ^ 8'hA5});
		frame(7, {8'h0B, 24'h001234, 8'h00, 24'h0}, rx);
		chk(rx[15:0], {8'h34 ^ 8'hA5, 8'h35 ^ 8'hA5});
		frame(3, {8'hFF, 56'h0}, rx);
		chk(master.drove, 1'b0);
	endtask
	task automatic t_latch();
		frame(1, {8'h06, 56'h0}, rx);
		status_read_cmd(st);
		chk(st, 8'h02);
		frame(1, {8'h04, 56'h0}, rx);
		status_read_cmd(st);
		chk(st[1], 1'b0);
		master.sel();
		master.xfer(8'h06, b);
		master.pulse(1);
		master.desel();
		status_read_cmd(st);
		chk(st[1], 1'b0);
	endtask
	// Mode 3: clock parked high, latch set then status read
	task automatic t_mode3();
		master.park(1'b1);
		master.sel();
		master.xfer3(8'h06, b);
		master.desel();
		master.sel();
		master.xfer3(8'h05, b);
		master.xfer3(8'h00, b);
		master.desel();
		master.park(1'b0);
		chk(b, 8'h02);
		frame(1, {8'h04, 56'h0}, rx);
	endtask
	// Pause mid-frame with clock noise, then a deselect inside a pause
	task automatic t_pause();
		frame(1, {8'h06, 56'h0}, rx);
		master.sel();
		master.xfer(8'h05, b);
		master.hold(1'b0);
		chk(so_oe_n, 1'b1);
		master.pulse(3);
		master.hold(1'b1);
		master.xfer(8'h00, b);
		chk(b, 8'h02);
		master.hold(1'b0);
		master.desel();
		master.hold(1'b1);
		status_read_cmd(st);
		chk(st, 8'h02);
		frame(1, {8'h04, 56'h0}, rx);
	endtask
	task automatic t_power();
		frame(1, {8'hB9, 56'h0}, rx);
		chk(low_power, 1'b1);
		frame(2, {8'h9F, 56'h0}, rx);
		chk(master.drove, 1'b0);
		frame(5, {8'hAB, 56'h0}, rx);
		chk(rx[7:0], DV);
		chk(low_power, 1'b0);
	endtask
	task automatic run_op(input int n, input logic [63:0] tx, input logic lat, input logic go,
		input sfcfe_op_e k, input logic [23:0] a);
		int s0;
		s0 = n_starts;
		if (lat) frame(1, {8'h06, 56'h0}, rx);
		frame(n, tx, rx);
		repeat (4) @(posedge clock);
		chk(n_starts - s0, go);
		if (go) begin
			chk(last_kind, k);
			if (k != OP_STATUS && k != OP_FULL) chk(last_addr, a);
			if (k == OP_FULL) begin
				frame(5, {8'h03, 56'h0}, rx);
				chk(master.drove, 1'b0);
				frame(2, {8'h9F, 56'h0}, rx);
				chk(master.drove, 1'b0);
			end
			wait_idle();
		end
	endtask
	task automatic t_ops();
		run_op(2, {8'h01, 8'hFF, 48'h0}, 1'b1, 1'b1, OP_STATUS, 24'h0);
		chk(status_byte, 8'h9C);
		run_op(4, {8'h20, 24'h123456, 32'h0}, 1'b1, 1'b1, OP_SMALL, 24'h023000);
		run_op(4, {8'h52, 24'h0ABCDE, 32'h0}, 1'b1, 1'b1, OP_LARGE, 24'h0A0000);
		run_op(4, {8'hD8, 24'h1FFFFF, 32'h0}, 1'b1, 1'b1, OP_LARGE, 24'h0F0000);
		run_op(1, {8'h60, 56'h0}, 1'b1, 1'b1, OP_FULL, 24'h0);
		run_op(1, {8'hC7, 56'h0}, 1'b1, 1'b1, OP_FULL, 24'h0);
		run_op(5, {8'h02, 24'h0FFF10, 32'h0}, 1'b1, 1'b1, OP_PAGE, 24'h0FFF10);
		run_op(4, {8'h20, 24'h001000, 32'h0}, 1'b0, 1'b0, OP_SMALL, 24'h0);
		run_op(3, {8'h20, 24'h001000, 32'h0}, 1'b1, 1'b0, OP_SMALL, 24'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		repeat (20) @(posedge clock);
		#2;
		sys_rst = 1'b0;
		repeat (10) @(posedge clock);
		chk(status_byte, 8'h00);
		t_ident();
		t_latch();
		t_mode3();
		t_pause();
		t_power();
		t_ops();
		finish_test();
	end
endmodule
